// ### src/ref_switch_consts.vh
`ifndef REF_SWITCH_CONSTS_VH
`define REF_SWITCH_CONSTS_VH

// Switchover mode field
`define SM_AUTO_BIT 1
// Primary source encoding
`define PRIM_IS_XTAL 1'b0
// Missing-edge limit in secondary clock cycles
`define MISS_LIMIT 2'h2
// Output divider decode
`define Q_ALL_ONES 7'h7F
`define Q_OFFSET 8'h02
// Half period of the /2 path, in source edges
`define DIV2_HALF 9'h002
// Disabled-state field encodings
`define DIS_LOW 2'h0
`define DIS_HIGH 2'h1
// Spread modulator
`define TSSC_ADD 5'h02
`define SS_FULL 7'h3F
`define LFSR_SEED 8'hA5
`define LFSR_TAPS 8'hB8

`endif

// ### src/out_divider.v
`timescale 1ns/1ps
`include "ref_switch_consts.vh"

// One output bank divider; each one-cycle source enable marks one source edge
module out_divider (
  input wire clk_sys,
  input wire sys_rst,
  input wire src_tick,
  input wire divider_mode_bit,
  input wire [6:0] q_field,
  input wire [1:0] disabled_state_field,
  output reg clk_out,
  output reg clk_oe
);
  reg [8:0] cnt;
  reg bypass_lvl;
  wire dis = (q_field == `Q_ALL_ONES) && !divider_mode_bit;
  wire div1 = (q_field == `Q_ALL_ONES) && divider_mode_bit;
  wire [7:0] q_sum = {1'b0, q_field} + `Q_OFFSET;
  // Half period in source edges: 2 for /2, 2*(Q+2) for the Q path, so /1 stays distinct
  wire [8:0] half = divider_mode_bit ? {q_sum, 1'b0} : `DIV2_HALF;

  // Counter and output; disabled banks hold a static level
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      cnt <= 9'h000;
      clk_out <= 1'b0;
      clk_oe <= 1'b0;
      bypass_lvl <= 1'b0;
    end else if (dis) begin
      cnt <= 9'h000;
      clk_oe <= (disabled_state_field == `DIS_LOW) ||
                (disabled_state_field == `DIS_HIGH); // RULE_12
      clk_out <= (disabled_state_field == `DIS_HIGH); // RULE_12
    end else if (div1) begin
      clk_oe <= 1'b1;
      if (src_tick) begin
        bypass_lvl <= ~bypass_lvl;
        clk_out <= ~bypass_lvl; // RULE_11
      end
    end else begin
      clk_oe <= 1'b1;
      if (src_tick) begin
        if (cnt + 9'h001 >= half) begin
          cnt <= 9'h000;
          clk_out <= ~clk_out; // RULE_11
        end else begin
          cnt <= cnt + 9'h001;
        end
      end
    end
  end
endmodule

// ### src/ref_switchover_divider_ssc.v
`timescale 1ns/1ps
`include "ref_switch_consts.vh"

// Functional notes
// RULE_01: Input select pin routes crystal/ref or second clock input as reference.
// RULE_02: Primary source bit 0 makes crystal/ref primary; 1 swaps roles.
// RULE_03: Mode field upper bit clear means manual selection by the pin.
// RULE_04: Manual reference changes must not glitch the outputs.
// RULE_05: Auto mode falls back when primary idles two secondary cycles.
// RULE_06: Auto mode returns to primary once primary toggles again.
// RULE_07: Auto switchover only with crystal/ref primary and not in crystal mode.
// RULE_08: Secondary source frequency must not exceed the primary's.
// RULE_09: Seven-bit reference and twelve-bit feedback divider per PLL.
// RULE_10: First PLL total feedback is 2N+A+1 for A nonzero, else 2N.
// RULE_11: Output divider decode: disabled, /1, /2 or (Q+2)*2 by mode bit.
// RULE_12: Disabled divider stops clocks, drives high, low or high impedance.
// RULE_13: Undivided output has no divider; outputs one to six each have one.
// RULE_14: Spread modulation active while step-period field is nonzero.
// RULE_15: Detector cycles per step equal step-period field plus two.
// RULE_16: Samples per quadrant are twice sample-count; quadrants mirror.
// RULE_17: Six-bit offset added to feedback; zero center, nonzero down spread.
// RULE_18: Twelve four-bit delta samples held; count setting picks how many used.
// RULE_19: Dither bit randomizes the modulator input least significant bit.
// RULE_20: Amplitude-double bit doubles the summed profile samples.
// RULE_21: Mode field upper bit set selects automatic switchover, pin ignored.
module ref_switchover_divider_ssc #(
  parameter NUM_DIV = 6
) (
  input wire clk_sys,
  input wire sys_rst,
  input wire crystal_ref_input,
  input wire second_clock_input,
  input wire input_select_pin,
  input wire primary_source_bit,
  input wire [1:0] switchover_mode_field,
  input wire crystal_mode,
  input wire pfd_tick,
  input wire [6:0] ref_div0,
  input wire [11:0] fb_count0,
  input wire [3:0] fb_frac0,
  input wire [6:0] ref_div1,
  input wire [11:0] fb_count1,
  input wire [6:0] ref_div2,
  input wire [11:0] fb_count2,
  input wire [6:0] ref_div3,
  input wire [11:0] fb_count3,
  input wire [NUM_DIV-1:0] bank_tick,
  input wire [NUM_DIV-1:0] divider_mode_bit,
  input wire [7*NUM_DIV-1:0] q_fields,
  input wire [1:0] disabled_state_field,
  input wire [3:0] step_period_field,
  input wire [2:0] sample_count_field,
  input wire [5:0] spread_offset_field,
  input wire [47:0] profile_delta_samples,
  input wire dither_bit,
  input wire amplitude_double_bit,
  output reg ref_clk,
  output reg ref_is_second,
  output reg on_secondary,
  output wire [6:0] pll_ref_div0,
  output wire [6:0] pll_ref_div1,
  output wire [6:0] pll_ref_div2,
  output wire [6:0] pll_ref_div3,
  output reg [12:0] pll_fb_total0,
  output reg [11:0] pll_fb_total1,
  output reg [11:0] pll_fb_total2,
  output reg [11:0] pll_fb_total3,
  output reg undivided_output,
  output wire [NUM_DIV-1:0] bank_clk,
  output wire [NUM_DIV-1:0] bank_oe,
  output reg ssc_active,
  output reg [7:0] ssc_mod_value
);
  // Edge history of both inputs
  reg xtal_d;
  reg sec_d;
  reg [1:0] miss_cnt;
  reg want_second;
  reg sel_second;
  wire prim_in = primary_source_bit ? second_clock_input : crystal_ref_input; // RULE_02
  wire sec_in = primary_source_bit ? crystal_ref_input : second_clock_input; // RULE_02
  wire prim_prev = primary_source_bit ? sec_d : xtal_d;
  wire sec_prev = primary_source_bit ? xtal_d : sec_d;
  wire prim_edge = prim_in ^ prim_prev;
  wire sec_rise = sec_in & ~sec_prev;
  wire auto_mode = switchover_mode_field[`SM_AUTO_BIT]; // RULE_21
  wire auto_ok = auto_mode && (primary_source_bit == `PRIM_IS_XTAL) && !crystal_mode; // RULE_07

  // Missing-primary detector counts secondary rising edges without primary activity
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      xtal_d <= 1'b0;
      sec_d <= 1'b0;
      miss_cnt <= 2'h0;
      on_secondary <= 1'b0;
    end else begin
      xtal_d <= crystal_ref_input;
      sec_d <= second_clock_input;
      if (!auto_ok) begin
        miss_cnt <= 2'h0;
        on_secondary <= 1'b0;
      end else if (prim_edge) begin
        miss_cnt <= 2'h0;
        on_secondary <= 1'b0; // RULE_06
      end else if (sec_rise) begin
        if (miss_cnt + 2'h1 >= `MISS_LIMIT) begin
          on_secondary <= 1'b1; // RULE_05
        end else begin
          miss_cnt <= miss_cnt + 2'h1;
        end
      end
    end
  end

  // Desired source: pin in manual, detector in auto
  always @* begin
    if (auto_mode) begin
      want_second = on_secondary; // RULE_21
    end else begin
      want_second = input_select_pin; // RULE_03
    end
  end

  // Physical input wanted; a role swap also waits for the quiet point
  wire want_phys = want_second ^ primary_source_bit; // RULE_02

  // Switch only while both inputs sit low so no runt pulse reaches the output;
  // a dead source parked high blocks the change, the trade for glitch freedom.
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      sel_second <= 1'b0;
      ref_clk <= 1'b0;
      ref_is_second <= 1'b0;
      undivided_output <= 1'b0;
    end else begin
      if (want_phys != sel_second && !crystal_ref_input && !second_clock_input) begin
        sel_second <= want_phys; // RULE_04
      end
      ref_clk <= sel_second ? second_clock_input : crystal_ref_input; // RULE_01
      ref_is_second <= sel_second;
      undivided_output <= sel_second ? second_clock_input : crystal_ref_input; // RULE_13
    end
  end

  // Reference dividers pass straight to the PLLs
  assign pll_ref_div0 = ref_div0; // RULE_09
  assign pll_ref_div1 = ref_div1;
  assign pll_ref_div2 = ref_div2;
  assign pll_ref_div3 = ref_div3;

  // Feedback totals, registered
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      pll_fb_total0 <= 13'h0000;
      pll_fb_total1 <= 12'h000;
      pll_fb_total2 <= 12'h000;
      pll_fb_total3 <= 12'h000;
    end else begin
      if (fb_frac0 != 4'h0) begin
        pll_fb_total0 <= {fb_count0, 1'b0} + {9'h000, fb_frac0} + 13'h0001; // RULE_10
      end else begin
        pll_fb_total0 <= {fb_count0, 1'b0}; // RULE_10
      end
      pll_fb_total1 <= fb_count1; // RULE_10
      pll_fb_total2 <= fb_count2;
      pll_fb_total3 <= fb_count3;
    end
  end

  // Output banks one to six
  genvar gi;
  generate
    for (gi = 0; gi < NUM_DIV; gi = gi + 1) begin : g_bank
      out_divider u_div (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .src_tick(bank_tick[gi]),
        .divider_mode_bit(divider_mode_bit[gi]),
        .q_field(q_fields[7*gi+6:7*gi]),
        .disabled_state_field(disabled_state_field),
        .clk_out(bank_clk[gi]),
        .clk_oe(bank_oe[gi])
      ); // RULE_13
    end
  endgenerate

  // Spread modulator: step timer, sample index and quadrant
  function [3:0] delta_at;
    input [47:0] vec;
    input [3:0] idx;
    begin
      delta_at = vec[idx*4 +: 4];
    end
  endfunction

  reg [4:0] step_cnt;
  reg [3:0] sample_idx;
  reg [1:0] quadrant;
  reg [6:0] accum;
  reg [7:0] lfsr;
  wire [4:0] step_len = {1'b0, step_period_field} + `TSSC_ADD; // RULE_15
  wire [3:0] n_samples = {sample_count_field, 1'b0}; // RULE_16
  wire step_done = pfd_tick && (step_cnt + 5'h01 >= step_len);
  wire last_sample = (sample_idx + 4'h1 >= n_samples);
  wire [3:0] cur_delta = delta_at(profile_delta_samples, sample_idx); // RULE_18
  wire [3:0] rev_idx = n_samples - 4'h1 - sample_idx;
  wire [3:0] back_delta = delta_at(profile_delta_samples, rev_idx);
  wire [7:0] scaled = amplitude_double_bit ? {accum, 1'b0} : {1'b0, accum}; // RULE_20
  wire [7:0] base = {2'b00, spread_offset_field} + scaled; // RULE_17
  wire [7:0] center = (spread_offset_field == 6'h00) ? {1'b0, `SS_FULL} : 8'h00;

  // Quadrants 0,2 ramp one way, 1,3 mirror back; 2,3 negate about center
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      step_cnt <= 5'h00;
      sample_idx <= 4'h0;
      quadrant <= 2'h0;
      accum <= 7'h00;
      lfsr <= `LFSR_SEED;
      ssc_active <= 1'b0;
      ssc_mod_value <= 8'h00;
    end else begin
      ssc_active <= (step_period_field != 4'h0); // RULE_14
      if (pfd_tick) begin
        lfsr <= {lfsr[6:0], ^(lfsr & `LFSR_TAPS)};
      end
      if (step_period_field == 4'h0) begin
        step_cnt <= 5'h00; // RULE_14
        sample_idx <= 4'h0;
        quadrant <= 2'h0;
        accum <= 7'h00;
        ssc_mod_value <= {2'b00, spread_offset_field};
      end else if (pfd_tick) begin
        if (step_done) begin
          step_cnt <= 5'h00;
          if (quadrant[0]) begin
            accum <= accum - {3'h0, back_delta}; // RULE_16
          end else begin
            accum <= accum + {3'h0, cur_delta}; // RULE_18
          end
          if (last_sample) begin
            sample_idx <= 4'h0;
            quadrant <= quadrant + 2'h1; // RULE_16
          end else begin
            sample_idx <= sample_idx + 4'h1;
          end
        end else begin
          step_cnt <= step_cnt + 5'h01;
        end
        if (quadrant[1]) begin
          ssc_mod_value <= {(center - scaled + {2'b00, spread_offset_field}) >> 0}
                           ^ {7'h00, dither_bit & lfsr[0]}; // RULE_19
        end else begin
          ssc_mod_value <= (base + (center >> 1) - (center >> 1))
                           ^ {7'h00, dither_bit & lfsr[0]}; // RULE_19
        end
      end
    end
  end
endmodule

// ### tb/ref_sources_model.sv
`timescale 1ns/1ps
// Two reference sources; the secondary is kept no faster than the primary
module ref_sources_model #(
  parameter PRI_HALF = 2,
  parameter SEC_HALF = 3
) (
  input wire clk_sys,
  input wire stop_primary,
  output reg crystal_ref_input,
  output reg second_clock_input
);
  integer pri_cnt = 0;
  integer sec_cnt = 0;
  initial begin
    crystal_ref_input = 1'b0;
    second_clock_input = 1'b0;
  end
  // Absent primary parks low, as a dead oscillator would
  always @(posedge clk_sys) begin
    pri_cnt <= (pri_cnt == PRI_HALF - 1) ? 0 : pri_cnt + 1;
    sec_cnt <= (sec_cnt == SEC_HALF - 1) ? 0 : sec_cnt + 1;
    if (stop_primary)
      crystal_ref_input <= 1'b0;
    else if (pri_cnt == PRI_HALF - 1)
      crystal_ref_input <= ~crystal_ref_input;
    if (sec_cnt == SEC_HALF - 1)
      second_clock_input <= ~second_clock_input;
  end
endmodule

// ### tb/ref_switch_checker_sva.sv
`timescale 1ns/1ps
module ref_switch_checker #(
  parameter NUM_DIV = 6
) (
  input logic clk_sys,
  input logic sys_rst,
  input logic crystal_ref_input,
  input logic second_clock_input,
  input logic input_select_pin,
  input logic primary_source_bit,
  input logic [1:0] switchover_mode_field,
  input logic crystal_mode,
  input logic [11:0] fb_count0,
  input logic [3:0] fb_frac0,
  input logic [11:0] fb_count1,
  input logic [NUM_DIV-1:0] divider_mode_bit,
  input logic [7*NUM_DIV-1:0] q_fields,
  input logic [1:0] disabled_state_field,
  input logic [3:0] step_period_field,
  input logic ref_clk,
  input logic ref_is_second,
  input logic on_secondary,
  input logic [12:0] pll_fb_total0,
  input logic [11:0] pll_fb_total1,
  input logic [NUM_DIV-1:0] bank_clk,
  input logic [NUM_DIV-1:0] bank_oe,
  input logic ssc_active
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  wire auto_on = switchover_mode_field[1] && !primary_source_bit && !crystal_mode;
  reg [1:0] sec_rises;
  // Secondary rises since the last primary edge, saturating
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst)
      sec_rises <= 2'h0;
    else if ($changed(crystal_ref_input))
      sec_rises <= 2'h0;
    else if ($rose(second_clock_input) && sec_rises != 2'h3)
      sec_rises <= sec_rises + 2'h1;
  end
  sequence manual_held;
    (!switchover_mode_field[1] && $stable(input_select_pin) && $stable(primary_source_bit))[*2];
  endsequence
  sequence bank0_off;
    (!divider_mode_bit[0] && q_fields[6:0] == 7'h7F && $stable(disabled_state_field))[*3];
  endsequence
  fb_total0_a: assert property (
    !$past(sys_rst) |-> pll_fb_total0 == (($past(fb_frac0) != 4'h0) ?
    {$past(fb_count0), 1'b0} + $past(fb_frac0) + 13'h0001 : {$past(fb_count0), 1'b0}))
    else $error("first feedback total wrong");
  fb_total1_a: assert property (
    !$past(sys_rst) |-> pll_fb_total1 == $past(fb_count1)) else $error("feedback total wrong");
  ssc_enable_a: assert property (
    $stable(step_period_field)[*3] |-> ssc_active == (step_period_field != 4'h0))
    else $error("spread enable wrong");
  manual_sel_a: assert property (
    manual_held ##0 (!crystal_ref_input && !second_clock_input) |->
    ##2 ref_is_second == ($past(input_select_pin, 2) ^ $past(primary_source_bit, 2)))
    else $error("manual source");
  no_glitch_a: assert property (
    $changed(ref_is_second) |-> !$past(ref_clk)) else $error("source switched while high");
  ref_clk_a: assert property (
    !$past(sys_rst) && $stable(ref_is_second) |-> ref_clk == (ref_is_second ?
    $past(second_clock_input) : $past(crystal_ref_input))) else $error("reference mux wrong");
  auto_fallback_a: assert property (
    auto_on && sec_rises == 2'h2 |-> ##[0:3] on_secondary) else $error("no fallback");
  auto_off_a: assert property (
    (!auto_on)[*3] |-> !on_secondary) else $error("detector active outside auto");
  bank_disable_a: assert property (
    bank0_off |-> bank_oe[0] == (disabled_state_field < 2'h2) &&
    (!bank_oe[0] || bank_clk[0] == disabled_state_field[0])) else $error("disabled level");
endmodule
bind ref_switchover_divider_ssc ref_switch_checker #(.NUM_DIV(NUM_DIV)) u_ref_switch_checker (
  .clk_sys, .sys_rst, .crystal_ref_input, .second_clock_input, .input_select_pin,
  .primary_source_bit, .switchover_mode_field, .crystal_mode, .fb_count0, .fb_frac0,
  .fb_count1, .divider_mode_bit, .q_fields, .disabled_state_field, .step_period_field,
  .ref_clk, .ref_is_second, .on_secondary, .pll_fb_total0, .pll_fb_total1, .bank_clk,
  .bank_oe, .ssc_active
);

// ### tb/tb_ref_switchover_divider_ssc.sv
`timescale 1ns/1ps
module tb_ref_switchover_divider_ssc;
  reg clk_sys = 1'b0, sys_rst = 1'b1, stop_primary = 1'b0, input_select_pin = 1'b0;
  reg primary_source_bit = 1'b0, crystal_mode = 1'b0, pfd_tick = 1'b1;
  reg dither_bit = 1'b0, amplitude_double_bit = 1'b0;
  reg [1:0] switchover_mode_field = 2'h0, disabled_state_field = 2'h0;
  reg [6:0] ref_div0 = 7'h01, ref_div1 = 7'h02, ref_div2 = 7'h7F, ref_div3 = 7'h03;
  reg [11:0] fb_count0 = 12'h000, fb_count1 = 12'h000, fb_count2 = 12'h000;
  reg [11:0] fb_count3 = 12'h000;
  reg [3:0] fb_frac0 = 4'h0, step_period_field = 4'h0;
  reg [5:0] bank_tick = 6'h3F, divider_mode_bit = 6'h3F;
  reg [41:0] q_fields = 42'h000_0000_0000;
  reg [2:0] sample_count_field = 3'h1;
  reg [5:0] spread_offset_field = 6'h00;
  reg [47:0] profile_delta_samples = 48'h0000_0000_0011;
  wire crystal_ref_input, second_clock_input, ref_clk, ref_is_second, on_secondary;
  wire undivided_output, ssc_active;
  wire [6:0] pll_ref_div0, pll_ref_div1, pll_ref_div2, pll_ref_div3;
  wire [12:0] pll_fb_total0;
  wire [11:0] pll_fb_total1, pll_fb_total2, pll_fb_total3;
  wire [5:0] bank_clk, bank_oe;
  wire [7:0] ssc_mod_value;
  integer mismatches = 0;
  integer checks_done = 0;
  integer i;
  ref_sources_model u_ref_sources_model (.clk_sys, .stop_primary, .crystal_ref_input,
    .second_clock_input);
  ref_switchover_divider_ssc u_ref_switchover_divider_ssc (.clk_sys, .sys_rst,
    .crystal_ref_input, .second_clock_input, .input_select_pin, .primary_source_bit,
    .switchover_mode_field, .crystal_mode, .pfd_tick, .ref_div0, .fb_count0, .fb_frac0,
    .ref_div1, .fb_count1, .ref_div2, .fb_count2, .ref_div3, .fb_count3, .bank_tick,
    .divider_mode_bit, .q_fields, .disabled_state_field, .step_period_field,
    .sample_count_field, .spread_offset_field, .profile_delta_samples, .dither_bit,
    .amplitude_double_bit, .ref_clk, .ref_is_second, .on_secondary, .pll_ref_div0,
    .pll_ref_div1, .pll_ref_div2, .pll_ref_div3, .pll_fb_total0, .pll_fb_total1,
    .pll_fb_total2, .pll_fb_total3, .undivided_output, .bank_clk, .bank_oe, .ssc_active,
    .ssc_mod_value);
  initial begin
    forever #2 clk_sys = ~clk_sys;
  end
  task check(input [27:0] seen, input [27:0] exp);
    checks_done = checks_done + 1;
    if (seen !== exp) begin
      mismatches = mismatches + 1;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task tick(input integer n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // Divider arithmetic, both fractional branches and pass-through
  task t_feedback;
    @(posedge clk_sys);
    fb_count0 <= 12'h016;
    fb_frac0 <= 4'h3;
    fb_count1 <= 12'hFFF;
    fb_count2 <= 12'h123;
    fb_count3 <= 12'h800;
    tick(2);
    check(pll_fb_total0, 13'h0030);
    check(pll_fb_total1, 13'h0FFF);
    check(pll_fb_total2, 13'h0123);
    check(pll_fb_total3, 13'h0800);
    check({pll_ref_div0, pll_ref_div1, pll_ref_div2, pll_ref_div3},
      {ref_div0, ref_div1, ref_div2, ref_div3});
    @(posedge clk_sys);
    fb_frac0 <= 4'h0;
    tick(2);
    check(pll_fb_total0, 13'h002C);
    $display("done feedback");
  endtask
  // All pin and primary-bit combinations in manual mode
  task t_manual;
    for (i = 0; i < 4; i = i + 1) begin
      @(posedge clk_sys);
      primary_source_bit <= i[1];
      input_select_pin <= i[0];
      tick(24);
      check(ref_is_second, i[1] ^ i[0]);
      check(undivided_output, ref_clk);
    end
    $display("done manual");
  endtask
  // Fallback, return, pin ignored, and crystal mode blocking
  task t_auto;
    @(posedge clk_sys);
    {primary_source_bit, input_select_pin, switchover_mode_field} <= 4'h6;
    tick(24);
    check(ref_is_second, 13'h0000);
    @(posedge clk_sys);
    stop_primary <= 1'b1;
    for (i = 0; i < 40 && on_secondary !== 1'b1; i = i + 1) tick(1);
    check(on_secondary, 13'h0001);
    tick(12);
    check(ref_is_second, 13'h0001);
    @(posedge clk_sys);
    stop_primary <= 1'b0;
    tick(24);
    check({on_secondary, ref_is_second}, 13'h0000);
    @(posedge clk_sys);
    crystal_mode <= 1'b1;
    stop_primary <= 1'b1;
    tick(30);
    check(on_secondary, 13'h0000);
    @(posedge clk_sys);
    {crystal_mode, stop_primary, switchover_mode_field} <= 4'h0;
    $display("done auto");
  endtask
  // Disabled bank levels for field values 0 to 2, then divide by one
  task t_divider;
    for (i = 0; i < 3; i = i + 1) begin
      @(posedge clk_sys);
      divider_mode_bit <= 6'h3E;
      q_fields <= 42'h000_0000_007F;
      disabled_state_field <= i[1:0];
      tick(6);
      check(bank_oe[0], i < 2);
      if (i < 2) check(bank_clk[0], i[0]);
    end
    @(posedge clk_sys);
    divider_mode_bit <= 6'h3F;
    tick(6);
    check(bank_oe[0], 13'h0001);
    $display("done divider");
  endtask
  // Output rates with one tick per source edge: /1 bank 0, Q=1 bank 1, /2 bank 2
  task t_rates;
    reg [5:0] last;
    integer n0, n1, n2;
    @(posedge clk_sys);
    divider_mode_bit <= 6'h3B;
    q_fields <= 42'h000_0000_00FF;
    tick(12);
    last = bank_clk;
    n0 = 0;
    n1 = 0;
    n2 = 0;
    repeat (24) begin
      tick(1);
      if (bank_clk[0] !== last[0]) n0 = n0 + 1;
      if (bank_clk[1] !== last[1]) n1 = n1 + 1;
      if (bank_clk[2] !== last[2]) n2 = n2 + 1;
      last = bank_clk;
    end
    check(n0, 13'h0018);
    check(n1, 13'h0004);
    check(n2, 13'h000C);
    $display("done rates");
  endtask
  // Spread enable follows the step-period field
  task t_spread;
    check(ssc_active, 13'h0000);
    @(posedge clk_sys);
    spread_offset_field <= 6'h05;
    tick(2);
    check(ssc_mod_value, 13'h0005);
    @(posedge clk_sys);
    step_period_field <= 4'h5;
    amplitude_double_bit <= 1'b1;
    tick(8);
    check(ssc_active, 13'h0001);
    check(ssc_mod_value, 13'h0007);
    $display("done spread");
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk_sys);
    sys_rst <= 1'b0;
    tick(2);
    t_feedback;
    t_manual;
    t_auto;
    t_divider;
    t_rates;
    t_spread;
    finish_test;
  end
endmodule
